// ---- logic/ioef_pkg.sv ----
// Package for the port E / port F GPIO block.
// Assumes word-aligned AXI4-Lite access; index = byte address / 4.
package ioef_pkg;
  localparam int E_W = 5;
  localparam int F_W = 8;
  localparam int IDX_W = 4;
  // Register indices
  localparam logic [IDX_W-1:0] IDX_E_DATA = 4'h8;
  localparam logic [IDX_W-1:0] IDX_F_DATA = 4'h9;
  localparam logic [IDX_W-1:0] IDX_E_KEY = 4'hA;
  localparam logic [IDX_W-1:0] IDX_F_KEY = 4'hB;
  localparam logic [IDX_W-1:0] IDX_E_DIR = 4'hC;
  localparam logic [IDX_W-1:0] IDX_F_DIR = 4'hD;
  localparam logic [IDX_W-1:0] IDX_OPT = 4'hE;
  localparam logic [IDX_W-1:0] IDX_F_PULL = 4'hF;
  // Optical control fields
  localparam int OPT_EN_X_BIT = 0;
  localparam int OPT_EN_Y_BIT = 1;
  localparam int OPT_REF_X_LSB = 2;
  localparam int OPT_REF_Y_LSB = 5;
  localparam int REF_W = 3;
  // Port E key register fields
  localparam int EKEY_IRQ_LSB = 0;
  localparam int EKEY_PU_LSB = 4;
  localparam int EKEY_N = 4;
  // Reset values
  localparam logic [E_W-1:0] E_DIR_RST = 5'h00;
  localparam logic [F_W-1:0] F_DIR_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  // Prescaler code that hands pin 0 to the timer clock
  localparam logic [2:0] PS_EXT_CLK = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ioef_pkg

// ---- logic/ioef_axil.sv ----
// AXI4-Lite slave front end for the GPIO block.
// Assumes the register file answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module ioef_axil
  import ioef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [IDX_W-1:0] wr_idx,
  output logic [7:0] wr_data,
  input wire logic wr_hit,
  output logic [IDX_W-1:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ioef_axi_s;

  ioef_axi_s q, d;

  function automatic logic in_map(input logic [ADDR_W-1:0] a);
    in_map = (a >> (IDX_W + 2)) == '0;
  endfunction : in_map

  assign awready = !q.aw_full && !q.bvalid;
  assign wready = !q.w_full && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rd_idx = araddr[IDX_W+1:2];
  assign wr_idx = q.aw_addr[IDX_W+1:2];
  assign wr_data = q.w_data;
  // Only lane 0 carries data; a write without it stores nothing
  assign wr_en = q.aw_full && q.w_full && !q.bvalid && q.w_lane0
    && in_map(q.aw_addr);

  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_full = 1'b1;
      d.w_data = wdata[7:0];
      d.w_lane0 = wstrb[0];
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (in_map(q.aw_addr) && wr_hit) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rd_data};
      d.rresp = (in_map(araddr) && rd_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ioef_axil
`default_nettype wire

// ---- logic/ioef_top.sv ----
// Port E (5 bit) and port F (8 bit) GPIO with timer sharing and
// optical interface controls, reached over AXI4-Lite.
// Assumes pads, timer, keyboard interrupt block and optical analog
// circuits sit outside and resolve the pin wires from the enables.
`timescale 1ns/1ps
`default_nettype none
module ioef_top
  import ioef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [E_W-1:0] PORT_E_IN,
  output logic [E_W-1:0] PORT_E_OUT,
  output logic [E_W-1:0] PORT_E_OE,
  input wire logic [F_W-1:0] PORT_F_IN,
  output logic [F_W-1:0] PORT_F_OUT,
  output logic [F_W-1:0] PORT_F_OE,
  output logic [EKEY_N-1:0] PORT_E_PULLUP_EN,
  output logic [F_W-1:0] PORT_F_PULLUP_EN,
  input wire logic [1:0] EDGE_LEVEL_SELECT_A,
  input wire logic [1:0] EDGE_LEVEL_SELECT_B,
  input wire logic [2:0] TIMER_PRESCALER_SELECT,
  input wire logic [1:0] TIMER_CH_OUT,
  input wire logic [1:0] TIMER_CH_OE,
  output logic [1:0] TIMER_CH_IN,
  output logic TIMER_EXT_CLK,
  output logic [EKEY_N-1:0] KEY_E_IRQ_EN,
  output logic [EKEY_N-1:0] KEY_E_PIN,
  output logic [F_W-1:0] KEY_F_IRQ_EN,
  output logic [F_W-1:0] KEY_F_PIN,
  output logic OPTICAL_ENABLE_X,
  output logic OPTICAL_ENABLE_Y,
  output logic [REF_W-1:0] REFERENCE_SELECT_X,
  output logic [REF_W-1:0] REFERENCE_SELECT_Y
);
  // Control and pad state, cleared by reset
  typedef struct packed {
    logic [E_W-1:0] e_dir;
    logic [F_W-1:0] f_dir;
    logic [7:0] opt;
    logic [7:0] e_key;
    logic [7:0] f_key;
    logic [7:0] f_pull;
    logic [E_W-1:0] e_s1;
    logic [E_W-1:0] e_s2;
    logic [F_W-1:0] f_s1;
    logic [F_W-1:0] f_s2;
    logic [E_W-1:0] e_out;
    logic [E_W-1:0] e_oe;
    logic [F_W-1:0] f_out;
    logic [F_W-1:0] f_oe;
    logic [EKEY_N-1:0] e_pu;
    logic [F_W-1:0] f_pu;
    logic [EKEY_N-1:0] e_kpin;
    logic [F_W-1:0] f_kpin;
    logic [1:0] tch_in;
    logic timer_external_clock_pin;
  } ioef_ctl_s;

  // Data latches keep their contents across reset
  typedef struct packed {
    logic [E_W-1:0] e_lat;
    logic [F_W-1:0] f_lat;
  } ioef_lat_s;

  ioef_ctl_s q, d;
  ioef_lat_s lq, ld;

  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [1:0] ch_claim;
  logic clk_claim;
  logic [E_W-1:0] e_oe_eff;
  logic [E_W-1:0] e_out_eff;

  // Per bit: output pins read the latch, input pins read the pad
  function automatic logic [7:0] rd_mix(input logic [7:0] dir,
                                        input logic [7:0] lat,
                                        input logic [7:0] pin);
    rd_mix = (dir & lat) | (~dir & pin);
  endfunction : rd_mix

  function automatic logic idx_known(input logic [IDX_W-1:0] idx);
    idx_known = idx >= IDX_E_DATA;
  endfunction : idx_known

  ioef_axil #(
    .ADDR_W(ADDR_W)
  ) u_axil (
    .clk(CLK),
    .resetn(RESETN),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  assign wr_hit = idx_known(wr_idx);
  assign rd_hit = idx_known(rd_idx);

  assign ch_claim = EDGE_LEVEL_SELECT_A | EDGE_LEVEL_SELECT_B;
  assign clk_claim = TIMER_PRESCALER_SELECT == PS_EXT_CLK;

  always_comb begin
    e_oe_eff = q.e_dir;
    e_out_eff = lq.e_lat;
    if (ch_claim[0]) begin
      e_oe_eff[1] = TIMER_CH_OE[0];
      e_out_eff[1] = TIMER_CH_OUT[0];
    end
    if (ch_claim[1]) begin
      e_oe_eff[2] = TIMER_CH_OE[1];
      e_out_eff[2] = TIMER_CH_OUT[1];
    end
    // Clock pin must not drive against the incoming clock
    if (clk_claim) begin
      e_oe_eff[0] = 1'b0;
    end
  end

  // Register read mux
  always_comb begin
    rd_data = 8'h00;
    case (rd_idx)
      IDX_E_DATA: rd_data = rd_mix({3'h0, q.e_dir}, {3'h0, lq.e_lat},
                                   {3'h0, q.e_s2});
      IDX_F_DATA: rd_data = rd_mix(q.f_dir, lq.f_lat, q.f_s2);
      IDX_E_KEY: rd_data = q.e_key;
      IDX_F_KEY: rd_data = q.f_key;
      IDX_E_DIR: rd_data = {3'h0, q.e_dir};
      IDX_F_DIR: rd_data = q.f_dir;
      IDX_OPT: rd_data = q.opt;
      IDX_F_PULL: rd_data = q.f_pull;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    ld = lq;
    // Two-stage pin synchronisers
    d.e_s1 = PORT_E_IN;
    d.e_s2 = q.e_s1;
    d.f_s1 = PORT_F_IN;
    d.f_s2 = q.f_s1;
    if (wr_en) begin
      case (wr_idx)
        IDX_E_DATA: ld.e_lat = wr_data[E_W-1:0];
        IDX_F_DATA: ld.f_lat = wr_data;
        IDX_E_KEY: d.e_key = wr_data;
        IDX_F_KEY: d.f_key = wr_data;
        IDX_E_DIR: d.e_dir = wr_data[E_W-1:0];
        IDX_F_DIR: d.f_dir = wr_data;
        IDX_OPT: d.opt = wr_data;
        IDX_F_PULL: d.f_pull = wr_data;
        default: d.opt = q.opt;
      endcase
    end
    d.e_oe = e_oe_eff;
    d.e_out = e_out_eff;
    d.f_oe = q.f_dir;
    d.f_out = lq.f_lat;
    d.e_pu = q.e_key[EKEY_PU_LSB +: EKEY_N] & ~e_oe_eff[EKEY_N-1:0];
    d.f_pu = q.f_pull & ~q.f_dir;
    d.e_kpin = q.e_s2[EKEY_N-1:0] & q.e_key[EKEY_IRQ_LSB +: EKEY_N];
    d.f_kpin = q.f_s2 & q.f_key;
    d.tch_in = q.e_s2[2:1] & ch_claim;
    d.timer_external_clock_pin = q.e_s2[0] & clk_claim;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.e_dir <= E_DIR_RST;
      q.f_dir <= F_DIR_RST;
      q.opt <= OPT_RST;
      q.e_key <= KEY_RST;
      q.f_key <= KEY_RST;
      q.f_pull <= PULL_RST;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge CLK) begin
    lq <= ld;
  end

  assign PORT_E_OUT = q.e_out;
  assign PORT_E_OE = q.e_oe;
  assign PORT_F_OUT = q.f_out;
  assign PORT_F_OE = q.f_oe;
  assign PORT_E_PULLUP_EN = q.e_pu;
  assign PORT_F_PULLUP_EN = q.f_pu;
  assign TIMER_CH_IN = q.tch_in;
  assign TIMER_EXT_CLK = q.timer_external_clock_pin;
  assign KEY_E_IRQ_EN = q.e_key[EKEY_IRQ_LSB +: EKEY_N];
  assign KEY_E_PIN = q.e_kpin;
  assign KEY_F_IRQ_EN = q.f_key;
  assign KEY_F_PIN = q.f_kpin;
  assign OPTICAL_ENABLE_X = q.opt[OPT_EN_X_BIT];
  assign OPTICAL_ENABLE_Y = q.opt[OPT_EN_Y_BIT];
  assign REFERENCE_SELECT_X = q.opt[OPT_REF_X_LSB +: REF_W];
  assign REFERENCE_SELECT_Y = q.opt[OPT_REF_Y_LSB +: REF_W];
endmodule : ioef_top
`default_nettype wire

// ---- verif/ioef_sva.sv ----
// Assertions on the ports of the port E / port F GPIO top.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ioef_sva
  import ioef_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [E_W-1:0] PORT_E_OE,
  input wire logic [F_W-1:0] PORT_F_OE,
  input wire logic [EKEY_N-1:0] PORT_E_PULLUP_EN,
  input wire logic [F_W-1:0] PORT_F_PULLUP_EN,
  input wire logic [1:0] EDGE_LEVEL_SELECT_A,
  input wire logic [1:0] EDGE_LEVEL_SELECT_B,
  input wire logic [2:0] TIMER_PRESCALER_SELECT,
  input wire logic [1:0] TIMER_CH_OE,
  input wire logic [1:0] TIMER_CH_IN,
  input wire logic TIMER_EXT_CLK,
  input wire logic [F_W-1:0] KEY_F_IRQ_EN,
  input wire logic [F_W-1:0] KEY_F_PIN,
  input wire logic OPTICAL_ENABLE_X,
  input wire logic OPTICAL_ENABLE_Y
);
  logic c0, c1, sel;
  assign c0 = EDGE_LEVEL_SELECT_A[0] | EDGE_LEVEL_SELECT_B[0];
  assign c1 = EDGE_LEVEL_SELECT_A[1] | EDGE_LEVEL_SELECT_B[1];
  assign sel = TIMER_PRESCALER_SELECT == PS_EXT_CLK;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Conditions held two edges, so one cycle of latency is tolerated
  a_reset_inputs: assert property ($rose(RESETN) |->
    PORT_E_OE == 5'h00 && PORT_F_OE == 8'h00) else $error("OE after reset");
  a_reset_optical: assert property ($rose(RESETN) |->
    !OPTICAL_ENABLE_X && !OPTICAL_ENABLE_Y) else $error("optical reset");
  a_e_pull_in: assert property (
    (PORT_E_PULLUP_EN & PORT_E_OE[3:0]) == 4'h0) else $error("E pull-up");
  a_f_pull_in: assert property (
    (PORT_F_PULLUP_EN & PORT_F_OE) == 8'h00) else $error("F pull-up");
  a_timer_drive: assert property (c0 && $past(c0) &&
    $stable(TIMER_CH_OE[0]) |-> PORT_E_OE[1] == TIMER_CH_OE[0])
    else $error("timer drive");
  a_ch_in_gate: assert property (!c1 && !$past(c1) |->
    !TIMER_CH_IN[1]) else $error("channel input");
  a_ext_clk_gate: assert property (!sel && !$past(sel) |->
    !TIMER_EXT_CLK) else $error("timer clock gate");
  a_clk_pin_in: assert property (sel && $past(sel) |->
    !PORT_E_OE[0]) else $error("clock pin drive");
  a_key_f_gate: assert property (
    (KEY_F_PIN & ~$past(KEY_F_IRQ_EN)) == 8'h00) else $error("key gate");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_clock: cover property (TIMER_EXT_CLK);
endmodule : ioef_sva
bind ioef_top ioef_sva u_sva (.CLK(CLK), .RESETN(RESETN),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PORT_E_OE(PORT_E_OE),
  .PORT_F_OE(PORT_F_OE), .PORT_E_PULLUP_EN(PORT_E_PULLUP_EN),
  .PORT_F_PULLUP_EN(PORT_F_PULLUP_EN),
  .EDGE_LEVEL_SELECT_A(EDGE_LEVEL_SELECT_A),
  .EDGE_LEVEL_SELECT_B(EDGE_LEVEL_SELECT_B),
  .TIMER_PRESCALER_SELECT(TIMER_PRESCALER_SELECT),
  .TIMER_CH_OE(TIMER_CH_OE), .TIMER_CH_IN(TIMER_CH_IN),
  .TIMER_EXT_CLK(TIMER_EXT_CLK), .KEY_F_IRQ_EN(KEY_F_IRQ_EN),
  .KEY_F_PIN(KEY_F_PIN), .OPTICAL_ENABLE_X(OPTICAL_ENABLE_X),
  .OPTICAL_ENABLE_Y(OPTICAL_ENABLE_Y));
`default_nettype wire

// ---- verif/ioef_pins.sv ----
// Pin wires and outside circuits of ports E and F.
// Assumes the block's drive overrides the bench on any pin that both drive.
`timescale 1ns/1ps
`default_nettype none
module ioef_pins
  import ioef_pkg::*;
(
  input wire logic clk,
  input wire logic [E_W-1:0] e_out,
  input wire logic [E_W-1:0] e_oe,
  input wire logic [E_W-1:0] e_xen,
  input wire logic [E_W-1:0] e_x,
  input wire logic [EKEY_N-1:0] e_pu,
  input wire logic [F_W-1:0] f_out,
  input wire logic [F_W-1:0] f_oe,
  input wire logic [F_W-1:0] f_pu,
  input wire logic [F_W-1:0] f_xen,
  input wire logic [F_W-1:0] f_x,
  output logic [E_W-1:0] e_in,
  output logic [F_W-1:0] f_in
);
  logic [7:0] flip_q = 8'h5A;
  logic [E_W-1:0] pu5;
  assign pu5 = {1'b0, e_pu};
  // Undriven pins toggle so a stale level never reads as a match
  always @(posedge clk) flip_q <= ~flip_q;
  // drive wins, pull-up only on released pins
  always_comb begin
    for (int i = 0; i < E_W; i++) e_in[i] = e_oe[i] ? e_out[i] :
      e_xen[i] ? e_x[i] : pu5[i] ? 1'b1 : flip_q[i];
    for (int i = 0; i < F_W; i++) f_in[i] = f_oe[i] ? f_out[i] :
      f_xen[i] ? f_x[i] : f_pu[i] ? 1'b1 : flip_q[i];
  end
endmodule : ioef_pins
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the GPIO top over AXI4-Lite.
// Assumes the pin model resolves every pin wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ioef_pkg::*;
  ;
  logic CLK = 0, RESETN = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr_rdy, bv, arr, rv, ox, oy, xclk;
  logic [7:0] awa = 0, ara = 0, f_xen = 8'hFF, f_x = 0, rd;
  logic [31:0] wd = 0, rdata;
  logic [1:0] bresp, rresp, rs, ea = 0, eb = 0, cho = 0, choe = 0, chi;
  logic [4:0] e_xen = 5'h1F, e_x = 0, e_in, e_out, e_oe;
  logic [3:0] e_pu, ke_en, ke_pin;
  logic [7:0] f_in, f_out, f_oe, f_pu, kf_en, kf_pin;
  logic [2:0] ps = 0, rx, ry;
  int err_count = 0, n_compared = 0;
  ioef_top dut (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .PORT_E_IN(e_in), .PORT_E_OUT(e_out),
    .PORT_E_OE(e_oe), .PORT_F_IN(f_in), .PORT_F_OUT(f_out),
    .PORT_F_OE(f_oe), .PORT_E_PULLUP_EN(e_pu), .PORT_F_PULLUP_EN(f_pu),
    .EDGE_LEVEL_SELECT_A(ea), .EDGE_LEVEL_SELECT_B(eb),
    .TIMER_PRESCALER_SELECT(ps), .TIMER_CH_OUT(cho), .TIMER_CH_OE(choe),
    .TIMER_CH_IN(chi), .TIMER_EXT_CLK(xclk), .KEY_E_IRQ_EN(ke_en),
    .KEY_E_PIN(ke_pin), .KEY_F_IRQ_EN(kf_en), .KEY_F_PIN(kf_pin),
    .OPTICAL_ENABLE_X(ox), .OPTICAL_ENABLE_Y(oy),
    .REFERENCE_SELECT_X(rx), .REFERENCE_SELECT_Y(ry));
  ioef_pins pins (.clk(CLK), .e_out(e_out), .e_oe(e_oe), .e_xen(e_xen),
    .e_x(e_x), .e_pu(e_pu), .f_out(f_out), .f_oe(f_oe), .f_pu(f_pu),
    .f_xen(f_xen), .f_x(f_x), .e_in(e_in), .f_in(f_in));
  initial forever #4 CLK = ~CLK;
  function automatic logic [7:0] ad(input logic [IDX_W-1:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge CLK);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_rdy === 1'b1) wv <= 1'b0;
      aw = aw | (awr === 1'b1);
      w = w | (wr_rdy === 1'b1);
    end while (!(aw && w));
    br <= 1'b1;
    do @(posedge CLK); while (bv !== 1'b1);
    rs = bresp;
    br <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(posedge CLK); while (arr !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge CLK); while (rv !== 1'b1);
    rd = rdata[7:0];
    rs = rresp;
    rr <= 1'b0;
  endtask : rdr
  task automatic wt;
    repeat (5) @(posedge CLK);
  endtask : wt
  task automatic t_port_e;
    e_x <= 5'h0A;
    wr(ad(IDX_E_DATA), 8'h15);
    chk(8'(rs), 8'(RESP_OKAY));
    wr(ad(IDX_E_DIR), 8'h03);
    wt;
    chk(8'(e_oe), 8'h03);
    chk(8'(e_out & e_oe), 8'h01);
    rdr(ad(IDX_E_DATA));
    chk(rd, 8'h09);
    wr(ad(IDX_E_DIR), 8'h1F);
    wt;
    rdr(ad(IDX_E_DATA));
    chk(rd, 8'h15);
    wr(ad(IDX_E_DIR), 8'h00);
    $display("test port_e done");
  endtask : t_port_e
  task automatic t_port_f;
    f_x <= 8'h3C;
    wr(ad(IDX_F_DATA), 8'hA5);
    wr(ad(IDX_F_DIR), 8'hF0);
    wr(ad(IDX_F_PULL), 8'hFF);
    wt;
    rdr(ad(IDX_F_DATA));
    chk(rd, 8'hAC);
    chk(f_oe, 8'hF0);
    chk(f_out & f_oe, 8'hA0);
    chk(f_pu, 8'h0F);
    $display("test port_f done");
  endtask : t_port_f
  task automatic t_timer;
    e_x <= 5'h00;
    ea <= 2'b01;
    eb <= 2'b10;
    choe <= 2'b11;
    cho <= 2'b01;
    wt;
    chk(8'(e_oe), 8'h06);
    chk(8'(chi), 8'h01);
    rdr(ad(IDX_E_DATA));
    chk(rd, 8'h02);
    ea <= 2'b00;
    eb <= 2'b00;
    ps <= PS_EXT_CLK;
    e_x <= 5'h01;
    wr(ad(IDX_E_DIR), 8'h01);
    wt;
    chk(8'({xclk, chi}), 8'h04);
    chk(8'(e_oe), 8'h00);
    ps <= 3'h0;
    wt;
    chk(8'({xclk, e_oe}), 8'h01);
    wr(ad(IDX_E_DIR), 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_opt;
    for (int c = 0; c < 8; c++) begin
      wr(ad(IDX_OPT), {3'(7 - c), 3'(c), 2'(c)});
      wt;
      chk(8'({oy, ox}), 8'(c % 4));
      chk(8'({ry, rx}), 8'({3'(7 - c), 3'(c)}));
    end
    $display("test optical done");
  endtask : t_opt
  task automatic t_keys;
    e_x <= 5'h0C;
    f_x <= 8'h96;
    f_xen <= 8'h0F;
    wr(ad(IDX_F_DIR), 8'h00);
    wr(ad(IDX_E_KEY), 8'hF5);
    wr(ad(IDX_F_KEY), 8'hFF);
    wt;
    chk(8'({ke_en, e_pu}), 8'h5F);
    chk(8'(ke_pin), 8'h04);
    chk(kf_pin & kf_en, 8'hF6);
    wr(ad(IDX_E_DIR), 8'h01);
    wt;
    chk(8'(e_pu), 8'h0E);
    f_xen <= 8'hFF;
    $display("test keys done");
  endtask : t_keys
  task automatic t_bad_and_reset;
    wr(8'h00, 8'hFF);
    chk(8'(rs), 8'(RESP_SLVERR));
    rdr(8'h04);
    chk({rd[7:2], rs}, 8'(RESP_SLVERR));
    wr(ad(IDX_F_DATA), 8'h5A);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    chk(8'(e_oe) | f_oe, 8'h00);
    rdr(ad(IDX_OPT));
    chk(rd, 8'h00);
    wr(ad(IDX_F_DIR), 8'hFF);
    wt;
    rdr(ad(IDX_F_DATA));
    chk(rd, 8'h5A);
    $display("test error_reset done");
  endtask : t_bad_and_reset
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    t_port_e;
    t_port_f;
    t_timer;
    t_opt;
    t_keys;
    t_bad_and_reset;
    test_done;
  end
  // Tests take well under 2000 cycles
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
